/* hcp_axil_slave.sv */
`default_nettype none
module hcp_axil_slave #(
  parameter int unsigned AW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          wvalid,
  output logic               wready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  output logic               bvalid,
  input  wire logic          bready,
  output logic [1:0]         bresp,
  input  wire logic          arvalid,
  output logic               arready,
  input  wire logic [AW-1:0] araddr,
  output logic               rvalid,
  input  wire logic          rready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               wr_en,
  output logic [3:0]         wr_idx,
  output logic [31:0]        wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_err,
  output logic               rd_en,
  output logic [3:0]         rd_idx,
  input  wire logic [31:0]   rd_data,
  input  wire logic          rd_err
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic        aw_full;
    logic [3:0]  aw_idx;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } hcp_axil_q_t;

  hcp_axil_q_t q;
  hcp_axil_q_t n;

  if (AW < 6)
  begin : g_bad_aw
    $error("hcp_axil_slave: address too narrow");
  end

  // Ready gated by ce so nothing is taken while frozen
  assign awready = ce & ~q.aw_full;
  assign wready  = ce & ~q.w_full;
  assign arready = ce & ~q.rvalid;
  assign wr_en   = ce & q.aw_full & q.w_full & ~q.bvalid;
  assign wr_idx  = q.aw_idx;
  assign wr_data = q.w_data;
  assign wr_strb = q.w_strb;
  assign rd_en   = arvalid & arready;
  assign rd_idx  = araddr[5:2];
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;

  always_comb
  begin
    n = q;
    if (awvalid & awready)
    begin
      n.aw_full = 1'b1;
      n.aw_idx  = awaddr[5:2];
    end
    if (wvalid & wready)
    begin
      n.w_full = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (q.bvalid & bready)
      n.bvalid = 1'b0;
    if (wr_en)
    begin
      n.aw_full = 1'b0;
      n.w_full  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = wr_err ? hcp_pkg::RESP_SLVERR : hcp_pkg::RESP_OKAY;
    end
    if (q.rvalid & rready)
      n.rvalid = 1'b0;
    if (rd_en)
    begin
      n.rvalid = 1'b1;
      n.rdata  = rd_data;
      n.rresp  = rd_err ? hcp_pkg::RESP_SLVERR : hcp_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else if (ce)
      q <= n;
  end
endmodule
`default_nettype wire

/* hcp_dev_model.sv */
`default_nettype none
module hcp_dev_model (
  input  wire logic       aclk,
  input  wire logic       sclk,
  input  wire logic       scs_n,
  input  wire logic       sdio_o,
  input  wire logic       sdio_oe,
  input  wire logic       pclk,
  input  wire logic       pcs_n,
  input  wire logic       prd_wr,
  input  wire logic [7:0] pbus_o,
  input  wire logic       pbus_oe,
  input  wire logic       io_update,
  output logic            sdio_i,
  output logic [7:0]      pbus_i,
  output logic            err
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] sr [32];
  logic [63:0] act [32];
  logic [7:0]  pm [256];
  logic [7:0]  ins, pa;
  logic [6:0]  bc;
  logic [2:0]  bp, p;
  logic [1:0]  pc;
  logic        lsb, nl, so, sdd, po, pr, fl;
  int          n;
  initial
  begin
    {bc, lsb, so, fl, err, pc} = '0;
    foreach (sr[i]) sr[i] = '0;
    foreach (act[i]) act[i] = '0;
  end
  // ****************************************
  // Serial port
  // ****************************************
  always @(posedge sclk)
    if (!scs_n)
    begin
      p = lsb ? bc[2:0] : 3'd7 - bc[2:0];
      if (bc < 8) ins[p] = sdio_i;
      n = (ins[4:0] == 5'h01) ? 2 : 4;
      if (bc == 7) bp = lsb ? 3'd0 : 3'(n - 1);
      if (bc > 7 && !ins[7]) sr[ins[4:0]][{bp, p}] = sdio_i;
      if (bc > 7 && bc[2:0] == 3'd7)
      begin
        nl = (ins[4:0] == 5'h00 && bp == 3'd2 && !ins[7]) ? sr[0][23] : lsb;
        lsb = nl;
        bp = nl ? bp + 3'd1 : bp - 3'd1;
      end
      bc = (bc == 7'(8 * n + 7)) ? 7'd0 : bc + 7'd1;
    end
  always @(negedge sclk)
  begin
    so = !scs_n && ins[7] && bc > 7;
    if (so) sdd = sr[ins[4:0]][{bp, lsb ? bc[2:0] : 3'd7 - bc[2:0]}];
  end
  // Released lines toggle so a stale level never reads as data
  always @(posedge aclk) fl <= ~fl;
  always @(posedge aclk) if ((so && sdio_oe) || (po && pbus_oe)) err <= 1'b1;
  assign sdio_i = sdio_oe ? sdio_o : so ? sdd : fl;
  // ****************************************
  // Parallel port
  // ****************************************
  always @(posedge pclk)
    if (!pcs_n)
    begin
      if (pc == 2'd0) pa = pbus_i;
      if (pc == 2'd0) pr = prd_wr;
      if (pc == 2'd1 && !pr) pm[pa] = pbus_i;
      pc = (pc == 2'd3) ? pc : pc + 2'd1;
    end
  always @(posedge pcs_n) pc = 2'd0;
  assign po = !pcs_n && pr && pc >= 2'd2;
  assign pbus_i = pbus_oe ? pbus_o : po ? pm[pa] : {8{fl}};
  always @(posedge io_update) foreach (act[i]) act[i] = sr[i];
endmodule
`default_nettype wire

/* hcp_host_ctrl.sv */
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`default_nettype none
module hcp_host_ctrl #(
  parameter int unsigned AXI_AW    = 8,
  parameter int unsigned SCLK_HALF = hcp_pkg::SCLK_HALF_CYC,
  parameter int unsigned PCLK_HALF = hcp_pkg::PCLK_HALF_CYC,
  parameter int unsigned UPD_CYC   = hcp_pkg::UPD_HOLD_CYC,
  parameter int unsigned MAX_BYTES = hcp_pkg::MAX_REG_BYTES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [AXI_AW-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   sclk,
  output logic                   scs_n,
  input  wire logic              sdio_i,
  output logic                   sdio_o,
  output logic                   sdio_oe,
  output logic                   pclk,
  output logic                   pcs_n,
  output logic                   prd_wr,
  input  wire logic [7:0]        pbus_i,
  output logic [7:0]             pbus_o,
  output logic                   pbus_oe,
  output logic                   io_update,
  output logic [2:0]             profile_select_pins
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    hcp_pkg::hcp_state_t st;
    logic [7:0]          cnt;
    logic                lclk;
    logic                sclk;
    logic                pclk;
    logic                scs_n;
    logic                sdio_o;
    logic                sdio_oe;
    logic                pcs_n;
    logic                prw;
    logic                pbus_oe;
    logic [7:0]          pbus_o;
    logic [2:0]          bitcnt;
    logic [2:0]          byte_idx;
    logic [3:0]          left;
    logic [3:0]          nb;
    logic                lsb;
    logic                rd;
    logic                par;
    logic                done;
    logic                io_upd;
    logic [7:0]          adr;
    logic [2:0]          ps;
    logic [63:0]         wd;
    logic [63:0]         rdat;
    logic [7:0]          updc;
    logic [2:0]          sd_s;
    logic                sd_f;
    logic [7:0]          pb_s0;
    logic [7:0]          pb_s1;
    logic [7:0]          pb_s2;
    logic [7:0]          pb_f;
  } hcp_q_t;

  hcp_q_t      q;
  hcp_q_t      n;
  logic        wr_en;
  logic [3:0]  wr_idx;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        rd_en;
  logic [3:0]  rd_idx;
  logic [31:0] rd_data;
  logic        idle;
  logic        tick;
  logic [7:0]  half_m1;
  logic [7:0]  ins_q;
  logic [7:0]  ins_w;
  logic [7:0]  pb_agree;
  logic        len_ok;
  logic [31:0] adr_word;

  if (SCLK_HALF < 4 || SCLK_HALF > 255 || PCLK_HALF < 4 || PCLK_HALF > 255 ||
      UPD_CYC < 1 || UPD_CYC > 255 || MAX_BYTES < 1 || MAX_BYTES > hcp_pkg::MAX_REG_BYTES)
  begin : g_bad_param
    $error("hcp_host_ctrl: parameter out of range");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic idx_ok(input logic [3:0] idx);
    idx_ok = (idx <= hcp_pkg::IDX_STAT);
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    wmerge = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        wmerge[b*8 +: 8] = nw[b*8 +: 8];
  endfunction

  // Bit position in the data word for byte and bit count
  function automatic logic [5:0] dpos(input logic [2:0] bi, input logic [2:0] bc, input logic lsb);
    dpos = {bi, (lsb ? bc : ~bc)};
  endfunction

  function automatic logic ins_bit(input logic [7:0] ins, input logic [2:0] bc, input logic lsb);
    ins_bit = lsb ? ins[bc] : ins[~bc];
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  hcp_axil_slave #(
    .AW (AXI_AW)
  ) u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (!idx_ok(wr_idx)),
    .rd_en   (rd_en),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_err  (!idx_ok(rd_idx))
  );

  assign idle     = (q.st == hcp_pkg::ST_IDLE);
  assign half_m1  = q.par ? 8'(PCLK_HALF - 1) : 8'(SCLK_HALF - 1);
  assign tick     = (q.cnt == half_m1);
  assign ins_q    = {q.rd, 2'b00, q.adr[4:0]};
  assign ins_w    = {wr_data[hcp_pkg::CTRL_RD], 2'b00, q.adr[4:0]};
  assign pb_agree = ~(q.pb_s1 ^ q.pb_s2);
  // Serial lengths of 1 to MAX_BYTES bytes only: a serial GO with zero or oversize length is refused
  assign len_ok   = (q.nb != 4'h0) && (q.nb <= 4'(MAX_BYTES));
  assign adr_word = {17'h00000, q.ps, q.nb, q.adr};

  always_comb
  begin
    rd_data = 32'h00000000;
    unique case (rd_idx)
      hcp_pkg::IDX_CTRL:
      begin
        rd_data[hcp_pkg::CTRL_PAR] = q.par;
        rd_data[hcp_pkg::CTRL_RD]  = q.rd;
      end
      hcp_pkg::IDX_ADDR: rd_data = adr_word;
      hcp_pkg::IDX_WDLO: rd_data = q.wd[31:0];
      hcp_pkg::IDX_WDHI: rd_data = q.wd[63:32];
      hcp_pkg::IDX_RDLO: rd_data = q.rdat[31:0];
      hcp_pkg::IDX_RDHI: rd_data = q.rdat[63:32];
      hcp_pkg::IDX_STAT:
      begin
        rd_data[hcp_pkg::STAT_BUSY] = ~idle;
        rd_data[hcp_pkg::STAT_LSB]  = q.lsb;
        rd_data[hcp_pkg::STAT_UPD]  = q.io_upd;
        rd_data[hcp_pkg::STAT_DONE] = q.done;
      end
      default: rd_data = 32'h00000000;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic        lsb_nx;
    logic [2:0]  bi_nx;
    logic [31:0] mw;
    lsb_nx = q.lsb;
    bi_nx  = q.byte_idx;
    mw     = 32'h00000000;
    n      = q;
    // Three-stage pin synchronisers, change taken when stages two and three agree
    n.sd_s  = {q.sd_s[1:0], sdio_i};
    if (q.sd_s[1] == q.sd_s[2])
      n.sd_f = q.sd_s[2];
    n.pb_s0 = pbus_i;
    n.pb_s1 = q.pb_s0;
    n.pb_s2 = q.pb_s1;
    n.pb_f  = (pb_agree & q.pb_s2) | (~pb_agree & q.pb_f);
    // Strobe held for a fixed count, well past one sync clock period
    if (q.updc != 8'h00)
      n.updc = q.updc - 8'h01;

    if (wr_en)
    begin
      unique case (wr_idx)
        hcp_pkg::IDX_CTRL:
        if (wr_strb[0])
        begin
          if (wr_data[hcp_pkg::CTRL_UPD] && q.updc == 8'h00)
            n.updc = 8'(UPD_CYC);
          if (wr_data[hcp_pkg::CTRL_GO] && idle)
          begin
            n.cnt  = 8'h00;
            n.lclk = 1'b0;
            if (wr_data[hcp_pkg::CTRL_PAR])
            begin
              n.par     = 1'b1;
              n.rd      = wr_data[hcp_pkg::CTRL_RD];
              n.st      = hcp_pkg::ST_PADR;
              n.pcs_n   = 1'b0;
              n.prw     = wr_data[hcp_pkg::CTRL_RD];
              n.pbus_o  = q.adr;
              n.pbus_oe = 1'b1;
            end
            else if (len_ok)
            begin
              n.par      = 1'b0;
              n.rd       = wr_data[hcp_pkg::CTRL_RD];
              n.st       = hcp_pkg::ST_SINS;
              n.scs_n    = 1'b0;
              n.sdio_oe  = 1'b1;
              n.sdio_o   = ins_bit(ins_w, 3'h0, q.lsb);
              n.bitcnt   = 3'h0;
              n.left     = q.nb;
              n.byte_idx = q.lsb ? 3'h0 : 3'(q.nb - 4'h1);
            end
          end
        end
        hcp_pkg::IDX_ADDR:
        if (idle)
        begin
          mw   = wmerge(adr_word, wr_data, wr_strb);
          n.adr = mw[hcp_pkg::ADDR_LSB +: 8];
          n.nb  = mw[hcp_pkg::LEN_LSB +: 4];
          n.ps  = mw[hcp_pkg::PS_LSB +: 3];
        end
        hcp_pkg::IDX_WDLO:
        if (idle)
          n.wd[31:0] = wmerge(q.wd[31:0], wr_data, wr_strb);
        hcp_pkg::IDX_WDHI:
        if (idle)
          n.wd[63:32] = wmerge(q.wd[63:32], wr_data, wr_strb);
        hcp_pkg::IDX_STAT:
        if (wr_strb[0] && wr_data[hcp_pkg::STAT_DONE])
          n.done = 1'b0;
        default: n.done = q.done;
      endcase
    end

    // Link clock divider; engine runs after the bus so a finishing set beats a clear
    if (!idle)
    begin
      n.cnt = tick ? 8'h00 : q.cnt + 8'h01;
      if (tick && !q.lclk)
      begin
        n.lclk = 1'b1;
        // Sample just before our rising edge: serial device drove after the falling one, parallel device after the previous rising one
        if (q.st == hcp_pkg::ST_SDAT && q.rd)
          n.rdat[dpos(q.byte_idx, q.bitcnt, q.lsb)] = q.sd_f;
        if (q.st == hcp_pkg::ST_PEND && q.rd)
          n.rdat[7:0] = q.pb_f;
      end
      else if (tick)
      begin
        n.lclk = 1'b0;
        unique case (q.st)
          hcp_pkg::ST_SINS:
          if (q.bitcnt == 3'h7)
          begin
            n.st     = hcp_pkg::ST_SDAT;
            n.bitcnt = 3'h0;
            n.sdio_oe = ~q.rd;
            if (!q.rd)
              n.sdio_o = q.wd[dpos(q.byte_idx, 3'h0, q.lsb)];
          end
          else
          begin
            n.bitcnt = q.bitcnt + 3'h1;
            n.sdio_o = ins_bit(ins_q, q.bitcnt + 3'h1, q.lsb);
          end
          hcp_pkg::ST_SDAT:
          if (q.bitcnt == 3'h7)
          begin
            // Writing the order byte sets the order from the next byte on, and it stays set for later cycles
            if (!q.rd && q.adr[4:0] == hcp_pkg::CONTROL_FUNCTION_REG_ONE_ADDR && q.byte_idx == hcp_pkg::ORDER_BYTE)
              lsb_nx = q.wd[hcp_pkg::ORDER_BIT];
            bi_nx  = lsb_nx ? q.byte_idx + 3'h1 : q.byte_idx - 3'h1;
            n.lsb  = lsb_nx;
            if (q.left == 4'h1)
            begin
              n.st      = hcp_pkg::ST_IDLE;
              n.scs_n   = 1'b1;
              n.sdio_oe = 1'b0;
              n.sdio_o  = 1'b0;
              n.done    = 1'b1;
            end
            else
            begin
              n.left     = q.left - 4'h1;
              n.byte_idx = bi_nx;
              n.bitcnt   = 3'h0;
              if (!q.rd)
                n.sdio_o = q.wd[dpos(bi_nx, 3'h0, lsb_nx)];
            end
          end
          else
          begin
            n.bitcnt = q.bitcnt + 3'h1;
            if (!q.rd)
              n.sdio_o = q.wd[dpos(q.byte_idx, q.bitcnt + 3'h1, q.lsb)];
          end
          hcp_pkg::ST_PADR:
          begin
            n.st = hcp_pkg::ST_PDAT;
            if (q.rd)
              n.pbus_oe = 1'b0;
            else
              n.pbus_o = q.wd[7:0];
          end
          hcp_pkg::ST_PDAT:
          begin
            n.st      = hcp_pkg::ST_PEND;
            n.pbus_oe = 1'b0;
          end
          hcp_pkg::ST_PEND:
          begin
            // Select released only after the third edge; never raised early
            n.st    = hcp_pkg::ST_IDLE;
            n.pcs_n = 1'b1;
            n.done  = 1'b1;
          end
          hcp_pkg::ST_IDLE: n.st = hcp_pkg::ST_IDLE;
        endcase
      end
    end
    n.io_upd = (n.updc != 8'h00);
    n.sclk   = n.lclk & ~n.par;
    n.pclk   = n.lclk & n.par;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q       <= '0;
      q.st    <= hcp_pkg::ST_IDLE;
      q.scs_n <= 1'b1;
      q.pcs_n <= 1'b1;
    end
    else if (ce)
      q <= n;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sclk                = q.sclk;
  assign scs_n               = q.scs_n;
  assign sdio_o              = q.sdio_o;
  assign sdio_oe             = q.sdio_oe;
  assign pclk                = q.pclk;
  assign pcs_n               = q.pcs_n;
  assign prd_wr              = q.prw;
  assign pbus_o              = q.pbus_o;
  assign pbus_oe             = q.pbus_oe;
  assign io_update           = q.io_upd;
  assign profile_select_pins = q.ps;
endmodule
`default_nettype wire

/* hcp_host_ctrl_bench.sv */
`default_nettype none
module hcp_host_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic        sclk, scs_n, sdio_i, sdio_o, sdio_oe, pclk, pcs_n, prd_wr, pbus_oe, io_update, err;
  logic [7:0]  awaddr, araddr, pbus_i, pbus_o;
  logic [31:0] wdata, rdata, v;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  pins;
  int          fails, total_checks;
  hcp_host_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
    .bready(1'b1), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(1'b1), .rdata(rdata), .rresp(rresp), .sclk(sclk), .scs_n(scs_n), .sdio_i(sdio_i),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .pclk(pclk), .pcs_n(pcs_n), .prd_wr(prd_wr), .pbus_i(pbus_i),
    .pbus_o(pbus_o), .pbus_oe(pbus_oe), .io_update(io_update), .profile_select_pins(pins));
  hcp_dev_model u_dev (.aclk(aclk), .sclk(sclk), .scs_n(scs_n), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .pclk(pclk), .pcs_n(pcs_n), .prd_wr(prd_wr), .pbus_o(pbus_o), .pbus_oe(pbus_oe),
    .io_update(io_update), .sdio_i(sdio_i), .pbus_i(pbus_i), .err(err));
  // ****************************************
  // Bus tasks
  // ****************************************
  // Ready levels are sampled mid-cycle so the edge never races
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ta, tv;
    araddr  <= a;
    arvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta  = arready;
      tv  = rvalid;
      d   = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tv);
  endtask
  task automatic go(input logic [31:0] c);
    logic [31:0] s;
    wr(8'h00, c);
    do rd(8'h18, s); while (s[hcp_pkg::STAT_DONE] !== 1'b1);
    wr(8'h18, 32'h00000008);
  endtask
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial
  begin
    #200000;
    fails++;
    stop_test;
  end
  initial
  begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, fails, total_checks} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("idle", {scs_n, pcs_n, sdio_oe, io_update}, 4'hC);
    wr(8'h08, 32'h0000A5C3);
    chk("wr_okay", rsp, hcp_pkg::RESP_OKAY);
    wr(8'h04, 32'h00000201);
    go(32'h1);
    chk("ser_wr", u_dev.sr[1], 64'hA5C3);
    go(32'h5);
    rd(8'h10, v);
    chk("ser_rd", v, 32'hA5C3);
    // Order flips after byte two, so bytes one and zero stay untouched
    wr(8'h0C, 32'h000000AB);
    wr(8'h08, 32'h5A801234);
    wr(8'h04, 32'h00000400);
    go(32'h1);
    chk("flip_wr", u_dev.sr[0], 64'h000000AB5A800000);
    rd(8'h18, v);
    chk("lsb_on", v[hcp_pkg::STAT_LSB], 1'b1);
    wr(8'h08, 32'h00003C96);
    wr(8'h04, 32'h00000201);
    go(32'h1);
    chk("lsb_wr", u_dev.sr[1], 64'h3C96);
    go(32'h5);
    rd(8'h10, v);
    chk("lsb_rd", v, 32'h3C96);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h04, 32'h00000400);
    go(32'h1);
    rd(8'h18, v);
    chk("lsb_off", v[hcp_pkg::STAT_LSB], 1'b0);
    wr(8'h08, 32'h0000005E);
    wr(8'h04, 32'h0000503C);
    go(32'h3);
    chk("par_wr", u_dev.pm[8'h3C], 8'h5E);
    go(32'h7);
    rd(8'h10, v);
    chk("par_rd", v[7:0], 8'h5E);
    chk("profile", pins, 3'h5);
    chk("held", u_dev.act[1], 64'h0);
    wr(8'h00, 32'h00000008);
    rd(8'h18, v);
    chk("upd_active", v[hcp_pkg::STAT_UPD], 1'b1);
    repeat (30) @(posedge aclk);
    chk("commit", u_dev.act[1], 64'h3C96);
    rd(8'h1C, v);
    chk("unmapped", rsp, hcp_pkg::RESP_SLVERR);
    wr(8'h1C, 32'h00000000);
    chk("wr_unmapped", rsp, hcp_pkg::RESP_SLVERR);
    chk("contention", err, 1'b0);
    stop_test;
  end
endmodule
`default_nettype wire

/* hcp_monitor.sv */
`default_nettype none
module hcp_monitor #(
  parameter int unsigned UPD_CYC = hcp_pkg::UPD_HOLD_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sclk,
  input wire logic scs_n,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic pclk,
  input wire logic pcs_n,
  input wire logic prd_wr,
  input wire logic pbus_oe,
  input wire logic io_update
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Strobe width counter
  // ****************************************
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  always_comb nxt_cnt = io_update ? cnt_ff + 16'h1 : 16'h0;
  always_ff @(posedge aclk) cnt_ff <= aresetn ? nxt_cnt : 16'h0;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  idle_reset_a: assert property ($rose(aresetn) |-> scs_n && pcs_n && !sdio_oe && !pbus_oe && !io_update)
    else $error("pins not idle after reset");
  sdio_steady_a: assert property ($rose(sclk) && sdio_oe |-> $stable(sdio_o))
    else $error("sdio moved at sclk rise");
  sclk_gated_a: assert property (scs_n |-> !sclk)
    else $error("sclk high with select off");
  sclk_half_a: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
    else $error("sclk half period wrong");
  sdio_own_a: assert property (sdio_oe |-> !scs_n)
    else $error("sdio driven unselected");
  upd_width_a: assert property ($fell(io_update) |-> cnt_ff == UPD_CYC)
    else $error("update strobe width wrong");
  par_rise_a: assert property ($fell(pcs_n) |-> !pclk [*6] ##1 pclk)
    else $error("first pclk rise late");
  par_len_a: assert property ($fell(pcs_n) |-> ##35 !pcs_n ##1 pcs_n)
    else $error("parallel access length wrong");
  rd_release_a: assert property ($fell(pcs_n) && prd_wr |-> pbus_oe [*8] ##5 !pbus_oe)
    else $error("read bus not released");
  wr_drive_a: assert property ($fell(pcs_n) && !prd_wr |-> ##18 pbus_oe ##6 !pbus_oe)
    else $error("write data not held");
  rw_hold_a: assert property (!pcs_n && !$fell(pcs_n) |-> $stable(prd_wr))
    else $error("direction moved in access");
  pbus_own_a: assert property (pbus_oe |-> !pcs_n)
    else $error("bus driven unselected");
  cover property ($fell(scs_n));
  cover property ($fell(pcs_n) && prd_wr);
  cover property ($rose(io_update));
endmodule
bind hcp_host_ctrl hcp_monitor #(.UPD_CYC(UPD_CYC)) u_mon (.aclk(aclk), .aresetn(aresetn), .sclk(sclk),
  .scs_n(scs_n), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .pclk(pclk), .pcs_n(pcs_n), .prd_wr(prd_wr),
  .pbus_oe(pbus_oe), .io_update(io_update));
`default_nettype wire

/* hcp_pkg.sv */
`default_nettype none
package hcp_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned SCLK_HALF_NS  = 60;
  localparam int unsigned PCLK_HALF_NS  = 60;
  localparam int unsigned UPD_HOLD_NS   = 200;
  // Least times, rounded up to whole cycles
  localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PCLK_HALF_CYC = (PCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned UPD_HOLD_CYC  = (UPD_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MAX_REG_BYTES = 8;
  localparam int unsigned DATA_W        = 64;
  // ****************************************
  // Register map (word index = byte offset / 4)
  // ****************************************
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_ADDR = 4'h1;
  localparam logic [3:0] IDX_WDLO = 4'h2;
  localparam logic [3:0] IDX_WDHI = 4'h3;
  localparam logic [3:0] IDX_RDLO = 4'h4;
  localparam logic [3:0] IDX_RDHI = 4'h5;
  localparam logic [3:0] IDX_STAT = 4'h6;
  localparam int unsigned CTRL_GO   = 0;
  localparam int unsigned CTRL_PAR  = 1;
  localparam int unsigned CTRL_RD   = 2;
  localparam int unsigned CTRL_UPD  = 3;
  localparam int unsigned ADDR_LSB  = 0;
  localparam int unsigned LEN_LSB   = 8;
  localparam int unsigned PS_LSB    = 12;
  localparam int unsigned STAT_BUSY = 0;
  localparam int unsigned STAT_LSB  = 1;
  localparam int unsigned STAT_UPD  = 2;
  localparam int unsigned STAT_DONE = 3;
  // ****************************************
  // Device instruction and order control
  // ****************************************
  localparam logic [4:0] CONTROL_FUNCTION_REG_ONE_ADDR = 5'h00;
  localparam logic [2:0] ORDER_BYTE = 3'h2;
  localparam int unsigned ORDER_BIT = 23;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SINS = 6'h02,
    ST_SDAT = 6'h04,
    ST_PADR = 6'h08,
    ST_PDAT = 6'h10,
    ST_PEND = 6'h20
  } hcp_state_t;
endpackage
`default_nettype wire
